// *** core/clkdiv_map.vh ***
`ifndef CLKDIV_MAP_VH
`define CLKDIV_MAP_VH
// register indices; byte address is four times the index
`define IDX_POWER_CTRL   10'h014
`define IDX_SOFT_RESET   10'h016
`define IDX_SYS_CLK      10'h018
`define IDX_PANEL_CLK    10'h030
`define IDX_PANEL_CFG    10'h032
`define IDX_DISP_OUT     10'h202
// index ranges untouched by a software reset
`define KEEP_LO_END      10'h018
`define KEEP_HI_START    10'h300
`define KEEP_HI_END      10'h31A
// writable bit masks, everything else reads zero except the memory idle bit in power control
`define MASK_POWER_CTRL  16'h0001
`define MASK_SYS_CLK     16'h0003
`define MASK_PANEL_CLK   16'h071F
`define MASK_PANEL_CFG   16'h0103
`define MASK_DISP_OUT    16'h1C00
// reset values
`define RST_POWER_CTRL   16'h0001
`define RST_SYS_CLK      16'h0000
`define RST_PANEL_CLK    16'h0000
`define RST_PANEL_CFG    16'h0000
`define RST_DISP_OUT     16'h0000
// field positions
`define PWR_SAVE_BIT     0
`define MEM_IDLE_BIT     6
`define SYS_DIV_LSB      0
`define SYS_DIV_MSB      1
`define PIX_DIV_LSB      0
`define PIX_DIV_MSB      4
`define SER_DIV_LSB      8
`define SER_DIV_MSB      10
`define PANEL_TYPE_LSB   0
`define PANEL_TYPE_MSB   1
`define SER_BYPASS_BIT   8
`define DISP_EN_LSB      10
`define DISP_EN_MSB      12
// panel interface codes
`define PANEL_RGB        2'h0
`define PANEL_PARALLEL   2'h2
// divisor offsets added to the field codes
`define SYS_DIV_OFFSET   3'h1
`define SER_DIV_OFFSET   5'h02
`define PIX_DIV_OFFSET   6'h02
// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// *** core/tick_divider.v ***
`timescale 1ns/100ps
// counts input ticks, emits one tick per ratio and a clock level
module tick_divider #(
  parameter W = 3
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         run,
  input  wire         tick_in,
  input  wire [W-1:0] ratio,
  output reg          tick_out,
  output reg          clk_out
);
  reg  [W-1:0] count;
  wire [W-1:0] last_count = ratio - {{(W-1){1'b0}}, 1'b1};
  wire         at_last    = (count >= last_count);
  wire [W-1:0] next_count = at_last ? {W{1'b0}} : count + {{(W-1){1'b0}}, 1'b1};

  // high for the first half of the period; odd ratios stay low one tick longer
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      count    <= {W{1'b0}};
      tick_out <= 1'b0;
      clk_out  <= 1'b0;
    end else begin
      tick_out <= tick_in && at_last;
      if (tick_in) begin
        count   <= next_count;
        clk_out <= (next_count < (ratio >> 1));
      end
    end
  end
endmodule

// *** core/reg_cell.v ***
`timescale 1ns/100ps
// one 16-bit register with byte enables and optional software reset
module reg_cell #(
  parameter [15:0] MASK       = 16'hFFFF,
  parameter [15:0] RESET      = 16'h0000,
  parameter        SOFT_CLEAR = 1
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        soft_rst,
  input  wire        wr_en,
  input  wire [1:0]  be,
  input  wire [15:0] wdata,
  output reg  [15:0] q
);
  wire [15:0] lane = {{8{be[1]}}, {8{be[0]}}} & MASK;

  // unmasked bits never take a write, so they read back zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= RESET;
    end else if (soft_rst && (SOFT_CLEAR != 0)) begin
      q <= RESET;
    end else if (wr_en) begin
      q <= (q & ~lane) | (wdata & lane);
    end
  end
endmodule

// *** core/clock_divider_soft_reset.v ***
// Summary of operation
// - reset-register write defaults all but kept ranges
// - software reset leaves display buffer alone
// - system divide field selects one to four
// - serial divide field selects two to sixteen
// - serial divider counts divided system clock ticks
// - serial divide ignored unless serial, not bypassed
// - pixel divisor is field code plus two
// - pixel divider counts divided system clock ticks
// - RGB panel uses pixel clock as shift clock
// - parallel panel times data with pixel clock
// - power save bit resets to one
// - panel type decodes RGB and parallel only
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "clkdiv_map.vh"
module clock_divider_soft_reset #(
  parameter ADDR_W = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              mem_idle,
  input  wire              serial_panel_sel,
  output reg               power_save,
  output reg  [2:0]        display_port_en,
  output reg               sys_tick,
  output reg               serial_clk,
  output reg               shift_clk,
  output reg               parallel_strobe,
  output reg               soft_reset_pulse
);
  // whether a register index survives a software reset
  function keep_on_soft;
    input [9:0] idx;
    begin
      keep_on_soft = (idx <= `KEEP_LO_END) ||
                     ((idx >= `KEEP_HI_START) && (idx <= `KEEP_HI_END));
    end
  endfunction

  localparam CLR_POWER_CTRL = keep_on_soft(`IDX_POWER_CTRL) ? 0 : 1;
  localparam CLR_SYS_CLK    = keep_on_soft(`IDX_SYS_CLK) ? 0 : 1;
  localparam CLR_PANEL_CLK  = keep_on_soft(`IDX_PANEL_CLK) ? 0 : 1;
  localparam CLR_PANEL_CFG  = keep_on_soft(`IDX_PANEL_CFG) ? 0 : 1;
  localparam CLR_DISP_OUT   = keep_on_soft(`IDX_DISP_OUT) ? 0 : 1;

  // write channel capture
  reg  [ADDR_W-1:0] aw_addr;
  reg               aw_got;
  reg  [15:0]       w_data;
  reg  [1:0]        w_be;
  reg               w_got;
  // read channel capture
  reg  [ADDR_W-1:0] ar_addr;
  reg               ar_got;

  wire [9:0] wr_idx  = aw_addr[11:2];
  wire [9:0] rd_idx  = ar_addr[11:2];
  wire       wr_fire = aw_got && w_got && !s_axi_bvalid;

  wire hit_power = (wr_idx == `IDX_POWER_CTRL);
  wire hit_soft  = (wr_idx == `IDX_SOFT_RESET);
  wire hit_sys   = (wr_idx == `IDX_SYS_CLK);
  wire hit_pclk  = (wr_idx == `IDX_PANEL_CLK);
  wire hit_cfg   = (wr_idx == `IDX_PANEL_CFG);
  wire hit_disp  = (wr_idx == `IDX_DISP_OUT);
  wire wr_mapped = hit_power || hit_soft || hit_sys || hit_pclk || hit_cfg || hit_disp;

  // any value, any lanes: the write itself is the trigger
  wire soft_rst = wr_fire && hit_soft;

  wire [15:0] q_power;
  wire [15:0] q_sys;
  wire [15:0] q_pclk;
  wire [15:0] q_cfg;
  wire [15:0] q_disp;

  // power save control, comes up set
  reg_cell #(
    .MASK       (`MASK_POWER_CTRL),
    .RESET      (`RST_POWER_CTRL),
    .SOFT_CLEAR (CLR_POWER_CTRL)
  ) u_power (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst),
    .wr_en    (wr_fire && hit_power),
    .be       (w_be),
    .wdata    (w_data),
    .q        (q_power)
  );

  // system clock divide, kept over a software reset
  reg_cell #(
    .MASK       (`MASK_SYS_CLK),
    .RESET      (`RST_SYS_CLK),
    .SOFT_CLEAR (CLR_SYS_CLK)
  ) u_sys (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst),
    .wr_en    (wr_fire && hit_sys),
    .be       (w_be),
    .wdata    (w_data),
    .q        (q_sys)
  );

  // serial and pixel divide fields
  reg_cell #(
    .MASK       (`MASK_PANEL_CLK),
    .RESET      (`RST_PANEL_CLK),
    .SOFT_CLEAR (CLR_PANEL_CLK)
  ) u_pclk (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst),
    .wr_en    (wr_fire && hit_pclk),
    .be       (w_be),
    .wdata    (w_data),
    .q        (q_pclk)
  );

  // panel type and serial bypass
  reg_cell #(
    .MASK       (`MASK_PANEL_CFG),
    .RESET      (`RST_PANEL_CFG),
    .SOFT_CLEAR (CLR_PANEL_CFG)
  ) u_cfg (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst),
    .wr_en    (wr_fire && hit_cfg),
    .be       (w_be),
    .wdata    (w_data),
    .q        (q_cfg)
  );

  // display output port enable field
  reg_cell #(
    .MASK       (`MASK_DISP_OUT),
    .RESET      (`RST_DISP_OUT),
    .SOFT_CLEAR (CLR_DISP_OUT)
  ) u_disp (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .soft_rst (soft_rst),
    .wr_en    (wr_fire && hit_disp),
    .be       (w_be),
    .wdata    (w_data),
    .q        (q_disp)
  );

  // field decode
  wire [1:0] sys_code   = q_sys[`SYS_DIV_MSB:`SYS_DIV_LSB];
  wire [2:0] ser_code   = q_pclk[`SER_DIV_MSB:`SER_DIV_LSB];
  wire [4:0] pix_code   = q_pclk[`PIX_DIV_MSB:`PIX_DIV_LSB];
  wire [1:0] panel_type = q_cfg[`PANEL_TYPE_MSB:`PANEL_TYPE_LSB];
  wire       ser_bypass = q_cfg[`SER_BYPASS_BIT];
  wire       is_rgb     = (panel_type == `PANEL_RGB);
  wire       is_par     = (panel_type == `PANEL_PARALLEL);
  wire       running    = !q_power[`PWR_SAVE_BIT];

  // divisors: code+1, 2*(code+1), code+2
  wire [2:0] sys_ratio = {1'b0, sys_code} + `SYS_DIV_OFFSET;
  wire [4:0] ser_ratio = {1'b0, ser_code, 1'b0} + `SER_DIV_OFFSET;
  wire [5:0] pix_ratio = {1'b0, pix_code} + `PIX_DIV_OFFSET;
  // serial divider holds still unless a non-bypassed serial panel is in use
  wire       ser_run   = running && is_par && serial_panel_sel && !ser_bypass;

  wire sys_pulse;
  wire ser_level;
  wire pix_pulse;
  wire pix_level;

  // divided system clock, one tick per ratio of aclk cycles
  tick_divider #(.W(3)) u_sysdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (running),
    .tick_in  (1'b1),
    .ratio    (sys_ratio),
    .tick_out (sys_pulse),
    .clk_out  ()
  );

  // serial clock counts system ticks, even ratios give a square wave
  tick_divider #(.W(5)) u_serdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ser_run),
    .tick_in  (sys_pulse),
    .ratio    (ser_ratio),
    .tick_out (),
    .clk_out  (ser_level)
  );

  // pixel clock counts system ticks; odd ratios with a divided
  // system clock are unsupported and produce an uneven duty cycle
  tick_divider #(.W(6)) u_pixdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (running),
    .tick_in  (sys_pulse),
    .ratio    (pix_ratio),
    .tick_out (pix_pulse),
    .clk_out  (pix_level)
  );

  // registered outputs; a software reset never touches the display buffer
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_save       <= 1'b1;
      display_port_en  <= 3'h0;
      sys_tick         <= 1'b0;
      serial_clk       <= 1'b0;
      shift_clk        <= 1'b0;
      parallel_strobe  <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      power_save       <= q_power[`PWR_SAVE_BIT];
      display_port_en  <= q_disp[`DISP_EN_MSB:`DISP_EN_LSB];
      sys_tick         <= sys_pulse;
      serial_clk       <= ser_run && ser_level; // gated so a stop takes effect at once
      shift_clk        <= is_rgb && pix_level;
      parallel_strobe  <= is_par && pix_pulse;
      soft_reset_pulse <= soft_rst;
    end
  end

  // write address and data are taken independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 16'h0000;
      w_be          <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata[15:0];
        w_be         <= s_axi_wstrb[1:0];
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // registers update on the same edge that raises bvalid
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read decode; the trigger register is write only and reads zero
  reg [15:0] rd_word;
  reg        rd_mapped;
  always @* begin
    rd_word   = 16'h0000;
    rd_mapped = 1'b1;
    if (rd_idx == `IDX_POWER_CTRL) begin
      rd_word = q_power;
      rd_word[`MEM_IDLE_BIT] = mem_idle;
    end else if (rd_idx == `IDX_SOFT_RESET) begin
      rd_word = 16'h0000;
    end else if (rd_idx == `IDX_SYS_CLK) begin
      rd_word = q_sys;
    end else if (rd_idx == `IDX_PANEL_CLK) begin
      rd_word = q_pclk;
    end else if (rd_idx == `IDX_PANEL_CFG) begin
      rd_word = q_cfg;
    end else if (rd_idx == `IDX_DISP_OUT) begin
      rd_word = q_disp;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // read channel: address taken, data answered on the next edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
      ar_got        <= 1'b0;
      ar_addr       <= {ADDR_W{1'b0}};
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr       <= s_axi_araddr;
        ar_got        <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (ar_got) begin
        ar_got       <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// *** verification/clkdiv_props.sv ***
`timescale 1ns/100ps
module clkdiv_props (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_bvalid,
  input wire       serial_panel_sel,
  input wire       power_save,
  input wire [2:0] display_port_en,
  input wire       sys_tick,
  input wire       serial_clk,
  input wire       shift_clk,
  input wire       parallel_strobe,
  input wire       soft_reset_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // power save and clocks after reset
  a_save_after_reset: assert property ($rose(aresetn) |-> power_save)
    else $error("power save clear after reset");
  a_save_holds_clocks: assert property (power_save && $past(power_save) &&
    $past(power_save, 2) |-> !sys_tick && !serial_clk && !shift_clk && !parallel_strobe)
    else $error("clock running in power save");
  // gap may be up to four cycles at the slowest system ratio
  a_tick_gap: assert property (sys_tick && !power_save |->
    ##[1:4] (sys_tick || power_save))
    else $error("system tick gap too long");
  a_strobe_single: assert property (parallel_strobe |=> !parallel_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_not_rgb: assert property (parallel_strobe |-> !shift_clk)
    else $error("strobe and shift clock together");
  a_serial_not_rgb: assert property (serial_clk |-> !shift_clk)
    else $error("serial clock with shift clock");
  a_serial_needs_sel: assert property (!serial_panel_sel && !$past(serial_panel_sel) &&
    !$past(serial_panel_sel, 2) |-> !serial_clk)
    else $error("serial clock without serial panel");
  // soft reset effects
  // pulse and write response rise on the same edge
  a_soft_after_write: assert property (soft_reset_pulse |-> s_axi_bvalid)
    else $error("soft reset pulse without write");
  // output copy of the port field lags the register by one cycle
  a_soft_clears_port: assert property (soft_reset_pulse |=> display_port_en == 3'h0)
    else $error("display port kept over soft reset");
  a_soft_keeps_save: assert property (soft_reset_pulse |-> $stable(power_save))
    else $error("power save changed by soft reset");

  c_soft: cover property (soft_reset_pulse);
  c_serial: cover property ($rose(serial_clk));
  c_strobe: cover property (parallel_strobe);
endmodule

bind clock_divider_soft_reset clkdiv_props u_props (
  .aclk, .aresetn, .s_axi_bvalid, .serial_panel_sel, .power_save, .display_port_en,
  .sys_tick, .serial_clk, .shift_clk, .parallel_strobe, .soft_reset_pulse
);

// *** verification/axil_host.sv ***
`timescale 1ns/100ps
module axil_host (
  input  wire        aclk,
  output reg  [11:0] s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [11:0] s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  // idle bus at time zero
  initial begin
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
  end

  // address and data offered together, each dropped once taken
  task automatic wr(input [9:0] idx, input [15:0] d, output [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // read waits for the answer however long it takes
  task automatic rd(input [9:0] idx, output [31:0] d, output [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
endmodule

// *** verification/test_clock_divider_soft_reset.sv ***
`timescale 1ns/100ps
`include "clkdiv_map.vh"
module test_clock_divider_soft_reset;
  logic        aclk, aresetn, mem_idle, serial_panel_sel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        power_save, sys_tick, serial_clk, shift_clk, parallel_strobe;
  logic        soft_reset_pulse;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, val;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [2:0]  display_port_en;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n, px, c;
  int          soft_seen = 0;

  clock_divider_soft_reset DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_idle, .serial_panel_sel, .power_save, .display_port_en,
    .sys_tick, .serial_clk, .shift_clk, .parallel_strobe, .soft_reset_pulse
  );

  axil_host host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );

  // 100 MHz clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // hang guard, well above the expected run length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  // soft reset pulses seen, one per trigger write
  always @(posedge aclk) begin
    if (soft_reset_pulse === 1'h1) begin
      soft_seen <= soft_seen + 1;
    end
  end

  task automatic end_sim();
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrc(input [9:0] idx, input [15:0] d);
    host.wr(idx, d, resp);
    check({14'h0000, resp}, {14'h0000, `RESP_OKAY});
  endtask

  task automatic rdc(input [9:0] idx, input [15:0] exp);
    host.rd(idx, val, resp);
    check(val[15:0], exp);
  endtask

  // 0 shift, 1 serial, 2 strobe, 3 system tick
  function automatic logic pick(input int s);
    case (s)
      0: return shift_clk;
      1: return serial_clk;
      2: return parallel_strobe;
      default: return sys_tick;
    endcase
  endfunction

  // high samples in 48 cycles; 48 divides evenly by every system ratio
  task automatic count(input int s, output int h);
    h = 0;
    repeat (48) begin
      @(posedge aclk);
      h = h + (pick(s) === 1'h1);
    end
  endtask

  // rise-to-rise period, skipping the first period after a change
  task automatic period(input int s, output int p);
    logic prev;
    int   rises;
    prev = 1'h1;
    rises = 0;
    p = 0;
    for (int i = 0; i < 600 && rises < 3; i++) begin
      @(posedge aclk);
      if (pick(s) === 1'h1 && !prev) rises++;
      if (rises == 2) p++;
      prev = pick(s) === 1'h1;
    end
  endtask

  initial begin
    aresetn = 1'h0;
    mem_idle = 1'h0;
    serial_panel_sel = 1'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(`IDX_POWER_CTRL, 16'h0001);
    check({15'h0000, power_save}, 16'h0001);
    rdc(`IDX_PANEL_CFG, 16'h0000);
    wrc(`IDX_SYS_CLK, 16'hFFFF);
    rdc(`IDX_SYS_CLK, 16'h0003);
    wrc(`IDX_PANEL_CLK, 16'hFFFF);
    rdc(`IDX_PANEL_CLK, 16'h071F);
    // unmapped index refused both ways
    host.wr(10'h100, 16'h1234, resp);
    check({14'h0000, resp}, {14'h0000, `RESP_SLVERR});
    host.rd(10'h100, val, resp);
    check({resp, val[13:0]}, {`RESP_SLVERR, 14'h0000});
    wrc(`IDX_SYS_CLK, 16'h0000);
    wrc(`IDX_POWER_CTRL, 16'h0000);
    // system ratio rises only; odd pixel ratios only at 1:1
    for (int s = 0; s < 4; s++) begin
      wrc(`IDX_SYS_CLK, 16'(s));
      count(3, n);
      check(n[15:0], 16'(48 / (s + 1)));
      for (int k = 0; k < 2; k++) begin
        px = (s == 0) + k * 30;
        c = k * 7;
        wrc(`IDX_PANEL_CLK, 16'(c * 256 + px));
        wrc(`IDX_PANEL_CFG, 16'h0000);
        period(0, n);
        check(n[15:0], 16'((px + 2) * (s + 1)));
        wrc(`IDX_PANEL_CFG, 16'h0002);
        period(2, n);
        check(n[15:0], 16'((px + 2) * (s + 1)));
        period(1, n);
        check(n[15:0], 16'(2 * (c + 1) * (s + 1)));
        count(0, n);
        check(n[15:0], 16'h0000);
        wrc(`IDX_PANEL_CFG, 16'h0102);
        count(1, n);
        check(n[15:0], 16'h0000);
      end
    end
    wrc(`IDX_PANEL_CFG, 16'h0002);
    serial_panel_sel <= 1'h0;
    count(1, n);
    check(n[15:0], 16'h0000);
    // soft reset spares power control and system clock
    wrc(`IDX_DISP_OUT, 16'hFFFF);
    rdc(`IDX_DISP_OUT, 16'h1C00);
    check({13'h0000, display_port_en}, 16'h0007);
    wrc(`IDX_SOFT_RESET, 16'h5A5A);
    rdc(`IDX_SOFT_RESET, 16'h0000);
    rdc(`IDX_DISP_OUT, 16'h0000);
    check({13'h0000, display_port_en}, 16'h0000);
    check(soft_seen[15:0], 16'h0001);
    rdc(`IDX_PANEL_CFG, 16'h0000);
    rdc(`IDX_PANEL_CLK, 16'h0000);
    rdc(`IDX_SYS_CLK, 16'h0003);
    rdc(`IDX_POWER_CTRL, 16'h0000);
    check({15'h0000, power_save}, 16'h0000);
    // power save entry: port off, memory idle seen, then the bit
    wrc(`IDX_DISP_OUT, 16'h0000);
    mem_idle <= 1'h1;
    rdc(`IDX_POWER_CTRL, 16'h0040);
    wrc(`IDX_POWER_CTRL, 16'h0001);
    // read back first: a last system tick may still be in flight
    rdc(`IDX_POWER_CTRL, 16'h0041);
    count(3, n);
    check(n[15:0], 16'h0000);
    check({15'h0000, power_save}, 16'h0001);
    end_sim();
  end
endmodule
